// ### include/ltms_pkg.sv
package ltms_pkg;

   // ***************************************************************
   // register map and reset values
   // ***************************************************************
   localparam logic [6:0] LTMS_ADDR_MUX_CTRL = 7'h18;
   localparam logic [6:0] LTMS_ADDR_DIODE_CTRL = 7'h19;
   localparam logic [7:0] LTMS_MUX_CTRL_RESET = 8'h00;
   localparam logic [7:0] LTMS_DIODE_CTRL_RESET = 8'h00;
   // implemented bits; the rest read as zero
   localparam logic [7:0] LTMS_MUX_CTRL_MASK = 8'h7F;
   localparam logic [7:0] LTMS_DIODE_CTRL_MASK = 8'h03;

   // ***************************************************************
   // serial frame layout
   // ***************************************************************
   localparam int LTMS_SPI_RW_BIT = 7;
   localparam logic [3:0] LTMS_SPI_ADDR_LAST = 4'h7;
   localparam logic [3:0] LTMS_SPI_DATA_LAST = 4'hF;

   // ***************************************************************
   // pair address landmarks and resolution variants
   // ***************************************************************
   localparam logic [4:0] LTMS_ADR_CLK_A0 = 5'h0F;
   localparam logic [4:0] LTMS_ADR_B_TOP = 5'h10;
   localparam logic [1:0] LTMS_RES_16 = 2'h0;
   localparam logic [1:0] LTMS_RES_14 = 2'h1;
   localparam logic [1:0] LTMS_RES_11 = 2'h3;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic reserved;
      logic test_mux_output_enable;
      logic [4:0] test_mux_pair_address;
      logic test_mux_pair_select;
   } ltms_mux_ctrl_t;

   typedef struct packed {
      logic [5:0] reserved;
      logic temp_diode_bias_select;
      logic temp_diode_enable;
   } ltms_diode_ctrl_t;

   typedef struct packed {
      logic lvds_data_clock_in;
      logic [15:0] port_a_lvds_data;
      logic [15:0] port_b_lvds_data;
   } ltms_lvds_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
   } ltms_spi_pins_t;

   typedef enum logic [1:0] {
      LTMS_SPI_IDLE = 2'b00,
      LTMS_SPI_ADDR = 2'b01,
      LTMS_SPI_DATA = 2'b10,
      LTMS_SPI_DONE = 2'b11
   } ltms_spi_state_t;

endpackage

// ### verification/ltms_host.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// serial host model
// ********************
module ltms_host (
   input wire logic clk_sys,
   input wire logic spi_sdo,
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_sdi
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_sdi = 1'b0;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic xfer(input logic [15:0] f, output logic [7:0] r);
      r = 8'h00;
      gap(1);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = f[i];
         gap(5);
         if (i < 8) begin
            r[i] = spi_sdo;
         end
         spi_sck = 1'b1;
         gap(5);
         spi_sck = 1'b0;
      end
      gap(5);
      spi_cs_n = 1'b1;
      // released line must not look like held data
      spi_sdi = ~spi_sdi;
      gap(6);
   endtask
endmodule
`default_nettype wire

// ### verification/ltms_props.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// test output, diode and serial line checks
// ********************
module ltms_props (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   input wire logic test_output_pair_pos,
   input wire logic test_output_pair_neg,
   input wire logic test_output_drive_en,
   input wire logic temp_diode_connect,
   input wire logic temp_diode_bias_on
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   idle_low_a: assert property (!test_output_drive_en |->
      !test_output_pair_pos && !test_output_pair_neg) else $error("idle pair driven");
   pair_inv_a: assert property (test_output_drive_en |->
      test_output_pair_neg != test_output_pair_pos) else $error("pair not complementary");
   pins_shared_a: assert property (temp_diode_connect |->
      !test_output_drive_en) else $error("diode and mux both on");
   bias_conn_a: assert property (temp_diode_bias_on |->
      temp_diode_connect) else $error("bias without diode");
   reset_out_a: assert property ($past(reset) |->
      !test_output_drive_en && !temp_diode_connect) else $error("outputs set after reset");
   oe_drop_a: assert property (spi_cs_n [*4] |=> !spi_sdo_oe) else $error("sdo kept driven");
   sdo_rest_a: assert property (spi_cs_n [*5] |-> !spi_sdo) else $error("sdo not low");
   ctrl_hold_a: assert property (spi_cs_n [*5] |=>
      $stable(test_output_drive_en) && $stable(temp_diode_connect)) else $error("ctrl moved");
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// test bench
// ********************
module tb
   import ltms_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic cs_n, sck, sdi, sdo, sdo_oe, pos, neg, drv, conn, bias, pos11, neg11, drv11;
   logic [1:0] e;
   logic dck = 1'b0;
   logic [15:0] pa = 16'h0000;
   logic [15:0] pb = 16'h0000;
   logic [7:0] rv;
   logic [15:0] pat [8] = '{16'h5555, 16'hAAAA, 16'h3333, 16'hCCCC,
      16'h0F0F, 16'hF0F0, 16'h00FF, 16'hFF00};
   int n_fail = 0;
   int samples_checked = 0;
   int n_oe = 0;
   always #25 clk_sys = ~clk_sys;
   // counts cycles with the read data line driven
   always @(posedge clk_sys) begin
      if (sdo_oe) begin
         n_oe++;
      end
   end
   ltms_host u_host (.clk_sys(clk_sys), .spi_sdo(sdo), .spi_cs_n(cs_n), .spi_sck(sck),
      .spi_sdi(sdi));
   ltms_top #(.DAC_VARIANT(LTMS_RES_16)) u_dut (.clk_sys(clk_sys), .reset(reset),
      .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
      .lvds_data_clock_in(dck), .port_a_lvds_data(pa), .port_b_lvds_data(pb),
      .test_output_pair_pos(pos), .test_output_pair_neg(neg),
      .test_output_drive_en(drv), .temp_diode_connect(conn), .temp_diode_bias_on(bias));
   // narrow part on the same pins, for pairs that do not exist there
   ltms_top #(.DAC_VARIANT(LTMS_RES_11)) u_dut_narrow (.clk_sys(clk_sys), .reset(reset),
      .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(), .spi_sdo_oe(),
      .lvds_data_clock_in(dck), .port_a_lvds_data(pa), .port_b_lvds_data(pb),
      .test_output_pair_pos(pos11), .test_output_pair_neg(neg11),
      .test_output_drive_en(drv11), .temp_diode_connect(), .temp_diode_bias_on());
   task automatic finish_test;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      int m;
      m = n_oe;
      u_host.xfer({1'b0, a, d}, rv);
      chk("oe", {7'h00, n_oe != m}, 8'h00);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      int m;
      m = n_oe;
      u_host.xfer({1'b1, a, 8'h00}, rv);
      chk("reg", rv, x);
      chk("oe", {7'h00, n_oe != m}, 8'h01);
   endtask
   // {exists, level at the positive pin} for a part with n data bits
   function automatic logic [1:0] pick(input int ad, input logic ms, input int n);
      int i;
      logic [15:0] w;
      i = (ad < 15) ? n - 2 - ad + int'(ms) : n + 15 - ad + int'(ms);
      w = (ad < 15) ? pa : pb;
      if (ad == 15) begin
         return ms ? {n == 16, ~pa[0]} : {1'b1, dck};
      end
      if (ad == 16) begin
         return ms ? {1'b1, ~dck} : {1'b1, pb[n - 1]};
      end
      if (i < 0 || i >= n) begin
         return 2'b00;
      end
      return {1'b1, w[i] ^ ms};
   endfunction
   // expected {drive, pos, neg}; an absent pair leaves all three low
   function automatic logic [7:0] trio(input logic [1:0] x);
      return {5'h00, x[1], x[1] & x[0], x[1] & ~x[0]};
   endfunction
   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      rd(LTMS_ADDR_MUX_CTRL, 8'h00);
      rd(LTMS_ADDR_DIODE_CTRL, 8'h00);
      rd(7'h2A, 8'h00);
      wr(LTMS_ADDR_MUX_CTRL, 8'hFF);
      rd(LTMS_ADDR_MUX_CTRL, LTMS_MUX_CTRL_MASK);
      for (int ad = 0; ad < 32; ad++) begin
         for (int ms = 0; ms < 2; ms++) begin
            wr(LTMS_ADDR_MUX_CTRL, {2'b01, ad[4:0], ms[0]});
            for (int k = 0; k < 8; k++) begin
               pa = pat[k];
               pb = ~pat[k];
               dck = k[1];
               u_host.gap(5);
               e = pick(ad, ms[0], 16);
               chk("route", {5'h00, drv, pos, neg}, trio(e));
               e = pick(ad, ms[0], 11);
               chk("narrow", {5'h00, drv11, pos11, neg11}, trio(e));
            end
         end
      end
      wr(LTMS_ADDR_MUX_CTRL, 8'h20);
      chk("off", {5'h00, drv, pos, neg}, 8'h00);
      wr(LTMS_ADDR_MUX_CTRL, 8'h00);
      wr(LTMS_ADDR_DIODE_CTRL, 8'h01);
      chk("diode", {6'h00, conn, bias}, 8'h02);
      wr(LTMS_ADDR_DIODE_CTRL, 8'hFF);
      chk("bias", {6'h00, conn, bias}, 8'h03);
      rd(LTMS_ADDR_DIODE_CTRL, LTMS_DIODE_CTRL_MASK);
      wr(7'h1A, 8'h55);
      rd(LTMS_ADDR_MUX_CTRL, 8'h00);
      reset = 1'b1;
      u_host.gap(12);
      reset = 1'b0;
      rd(LTMS_ADDR_DIODE_CTRL, 8'h00);
      chk("rst", {6'h00, conn, bias}, 8'h00);
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_fail++;
      finish_test();
   end
endmodule
bind ltms_top ltms_props u_props (
   .clk_sys(clk_sys),
   .reset(reset),
   .spi_cs_n(spi_cs_n),
   .spi_sdo(spi_sdo),
   .spi_sdo_oe(spi_sdo_oe),
   .test_output_pair_pos(test_output_pair_pos),
   .test_output_pair_neg(test_output_pair_neg),
   .test_output_drive_en(test_output_drive_en),
   .temp_diode_connect(temp_diode_connect),
   .temp_diode_bias_on(temp_diode_bias_on)
);
`default_nettype wire

// ### verilog/ltms_route.sv
`timescale 1ns/10ps
`default_nettype none

module ltms_route
   import ltms_pkg::*;
#(
   parameter logic [1:0] DAC_VARIANT = LTMS_RES_16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire ltms_mux_ctrl_t ctrl,
   input wire ltms_lvds_t lvds,
   output logic pos_q,
   output logic neg_q,
   output logic drive_q
);

   // ***************************************************************
   // pair decode
   // ***************************************************************
   function automatic int width_of(input logic [1:0] variant);
      int n;
      n = 16;
      if (variant == LTMS_RES_14) begin
         n = 14;
      end else if (variant == LTMS_RES_11) begin
         n = 11;
      end
      return n;
   endfunction

   // returns {exists, raw level}
   function automatic logic [1:0] pick(input logic [4:0] adr, input logic msel,
                                       input ltms_lvds_t s, input int n);
      int a;
      int idx;
      logic [1:0] r;
      a = int'(adr);
      idx = 0;
      r = 2'b00;
      if (adr == LTMS_ADR_CLK_A0) begin
         if (!msel) begin
            r = {1'b1, s.lvds_data_clock_in};
         end else if (n == 16) begin
            r = {1'b1, s.port_a_lvds_data[0]};
         end
      end else if (adr == LTMS_ADR_B_TOP) begin
         if (!msel) begin
            r = {1'b1, s.port_b_lvds_data[4'(n - 1)]};
         end else begin
            r = {1'b1, s.lvds_data_clock_in};
         end
      end else begin
         if (a < 15) begin
            idx = n - 2 - a + int'(msel);
         end else begin
            idx = n + 15 - a + int'(msel);
         end
         if (idx >= 0 && idx < n) begin
            r[1] = 1'b1;
            r[0] = (a < 15) ? s.port_a_lvds_data[4'(idx)] : s.port_b_lvds_data[4'(idx)];
         end
      end
      return r;
   endfunction

   // ***************************************************************
   // output stage
   // ***************************************************************
   logic pos_d;
   logic neg_d;
   logic drive_d;
   logic [1:0] sel;

   always_comb begin
      sel = pick(ctrl.test_mux_pair_address, ctrl.test_mux_pair_select,
                 lvds, width_of(DAC_VARIANT));
      drive_d = ctrl.test_mux_output_enable & sel[1];
      pos_d = 1'b0;
      neg_d = 1'b0;
      if (drive_d) begin
         pos_d = sel[0] ^ ctrl.test_mux_pair_select;
         neg_d = ~pos_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pos_q <= 1'b0;
         neg_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         pos_q <= pos_d;
         neg_q <= neg_d;
         drive_q <= drive_d;
      end
   end

endmodule

`default_nettype wire

// ### verilog/ltms_top.sv
// How it works
// - bit 0 picks member of pair
// - bits 5:1 address the input pair
// - address steps port A, clock, port B
// - member one output inverted, member zero plain
// - drive test output only while enabled
// - mux control resets to zero
// - diode connects after mux enable cleared
// - bias select picks biased or bare diode
// - diode control resets to zero
`timescale 1ns/10ps
`default_nettype none

module ltms_top
   import ltms_pkg::*;
#(
   parameter logic [1:0] DAC_VARIANT = LTMS_RES_16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic lvds_data_clock_in,
   input wire logic [15:0] port_a_lvds_data,
   input wire logic [15:0] port_b_lvds_data,
   output logic test_output_pair_pos,
   output logic test_output_pair_neg,
   output logic test_output_drive_en,
   output logic temp_diode_connect,
   output logic temp_diode_bias_on
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   ltms_spi_pins_t spi_meta_q;
   ltms_spi_pins_t spi_sync_q;
   logic sck_prev_q;
   ltms_lvds_t lvds_meta_q;
   ltms_lvds_t lvds_sync_q;
   ltms_spi_pins_t spi_meta_d;
   ltms_spi_pins_t spi_sync_d;
   logic sck_prev_d;
   ltms_lvds_t lvds_meta_d;
   ltms_lvds_t lvds_sync_d;

   always_comb begin
      spi_meta_d = '{cs_n: spi_cs_n, sck: spi_sck, sdi: spi_sdi};
      spi_sync_d = spi_meta_q;
      sck_prev_d = spi_sync_q.sck;
      lvds_meta_d = '{lvds_data_clock_in: lvds_data_clock_in,
                      port_a_lvds_data: port_a_lvds_data,
                      port_b_lvds_data: port_b_lvds_data};
      lvds_sync_d = lvds_meta_q;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         spi_meta_q <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         spi_sync_q <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         sck_prev_q <= 1'b0;
         lvds_meta_q <= '0;
         lvds_sync_q <= '0;
      end else begin
         spi_meta_q <= spi_meta_d;
         spi_sync_q <= spi_sync_d;
         sck_prev_q <= sck_prev_d;
         lvds_meta_q <= lvds_meta_d;
         lvds_sync_q <= lvds_sync_d;
      end
   end

   // ***************************************************************
   // register read decode
   // ***************************************************************
   function automatic logic [7:0] read_reg(input logic [6:0] adr,
                                           input ltms_mux_ctrl_t mux,
                                           input ltms_diode_ctrl_t dio);
      logic [7:0] r;
      r = 8'h00;
      if (adr == LTMS_ADDR_MUX_CTRL) begin
         r = mux & LTMS_MUX_CTRL_MASK;
      end else if (adr == LTMS_ADDR_DIODE_CTRL) begin
         r = dio & LTMS_DIODE_CTRL_MASK;
      end
      return r;
   endfunction

   // ***************************************************************
   // serial slave and registers
   // ***************************************************************
   ltms_spi_state_t state_q;
   ltms_spi_state_t state_d;
   logic [3:0] bit_cnt_q;
   logic [3:0] bit_cnt_d;
   logic [7:0] shin_q;
   logic [7:0] shin_d;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [7:0] shout_q;
   logic [7:0] shout_d;
   logic sdo_q;
   logic sdo_d;
   logic sdo_oe_q;
   logic sdo_oe_d;
   ltms_mux_ctrl_t mux_ctrl_q;
   ltms_mux_ctrl_t mux_ctrl_d;
   ltms_diode_ctrl_t diode_ctrl_q;
   ltms_diode_ctrl_t diode_ctrl_d;
   logic diode_conn_q;
   logic diode_conn_d;
   logic diode_bias_q;
   logic diode_bias_d;
   logic sck_rise;
   logic sck_fall;
   logic [7:0] byte_in;

   always_comb begin
      sck_rise = spi_sync_q.sck & ~sck_prev_q;
      sck_fall = ~spi_sync_q.sck & sck_prev_q;
      byte_in = {shin_q[6:0], spi_sync_q.sdi};
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shin_d = shin_q;
      addr_d = addr_q;
      shout_d = shout_q;
      sdo_d = sdo_q;
      sdo_oe_d = sdo_oe_q;
      mux_ctrl_d = mux_ctrl_q;
      diode_ctrl_d = diode_ctrl_q;
      if (spi_sync_q.cs_n) begin
         state_d = LTMS_SPI_IDLE;
         bit_cnt_d = 4'h0;
         sdo_d = 1'b0;
         sdo_oe_d = 1'b0;
      end else begin
         unique case (state_q)
            LTMS_SPI_IDLE: begin
               state_d = LTMS_SPI_ADDR;
               bit_cnt_d = 4'h0;
            end
            LTMS_SPI_ADDR: begin
               if (sck_rise) begin
                  shin_d = byte_in;
                  bit_cnt_d = bit_cnt_q + 4'h1;
                  if (bit_cnt_q == LTMS_SPI_ADDR_LAST) begin
                     addr_d = byte_in;
                     state_d = LTMS_SPI_DATA;
                     if (byte_in[LTMS_SPI_RW_BIT]) begin
                        shout_d = read_reg(byte_in[6:0], mux_ctrl_q, diode_ctrl_q);
                        sdo_oe_d = 1'b1;
                     end
                  end
               end
            end
            LTMS_SPI_DATA: begin
               if (sck_fall && addr_q[LTMS_SPI_RW_BIT]) begin
                  sdo_d = shout_q[7];
                  shout_d = {shout_q[6:0], 1'b0};
               end
               if (sck_rise) begin
                  shin_d = byte_in;
                  bit_cnt_d = bit_cnt_q + 4'h1;
                  if (bit_cnt_q == LTMS_SPI_DATA_LAST) begin
                     state_d = LTMS_SPI_DONE;
                     if (!addr_q[LTMS_SPI_RW_BIT]) begin
                        if (addr_q[6:0] == LTMS_ADDR_MUX_CTRL) begin
                           mux_ctrl_d = byte_in & LTMS_MUX_CTRL_MASK;
                        end else if (addr_q[6:0] == LTMS_ADDR_DIODE_CTRL) begin
                           diode_ctrl_d = byte_in & LTMS_DIODE_CTRL_MASK;
                        end
                     end
                  end
               end
            end
            LTMS_SPI_DONE: begin
               state_d = LTMS_SPI_DONE;
            end
         endcase
      end
      // diode only while the mux has let go of the shared pins
      diode_conn_d = diode_ctrl_q.temp_diode_enable
                     & ~mux_ctrl_q.test_mux_output_enable;
      diode_bias_d = diode_conn_d & diode_ctrl_q.temp_diode_bias_select;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= LTMS_SPI_IDLE;
         bit_cnt_q <= 4'h0;
         shin_q <= 8'h00;
         addr_q <= 8'h00;
         shout_q <= 8'h00;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
         mux_ctrl_q <= LTMS_MUX_CTRL_RESET;
         diode_ctrl_q <= LTMS_DIODE_CTRL_RESET;
         diode_conn_q <= 1'b0;
         diode_bias_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shin_q <= shin_d;
         addr_q <= addr_d;
         shout_q <= shout_d;
         sdo_q <= sdo_d;
         sdo_oe_q <= sdo_oe_d;
         mux_ctrl_q <= mux_ctrl_d;
         diode_ctrl_q <= diode_ctrl_d;
         diode_conn_q <= diode_conn_d;
         diode_bias_q <= diode_bias_d;
      end
   end

   // ***************************************************************
   // test output routing
   // ***************************************************************
   ltms_route #(
      .DAC_VARIANT(DAC_VARIANT)
   ) u_route (
      .clk_sys(clk_sys),
      .reset(reset),
      .ctrl(mux_ctrl_q),
      .lvds(lvds_sync_q),
      .pos_q(test_output_pair_pos),
      .neg_q(test_output_pair_neg),
      .drive_q(test_output_drive_en)
   );

   assign spi_sdo = sdo_q;
   assign spi_sdo_oe = sdo_oe_q;
   assign temp_diode_connect = diode_conn_q;
   assign temp_diode_bias_on = diode_bias_q;

endmodule

`default_nettype wire
